// ---- rtl/cca_pkg.sv ----
// package for the compare/capture array: register map, field positions, reset values
// assumes a 32-bit apb slave with word-aligned registers
package cca_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_TB_LOW = 8'h08;
  localparam logic [7:0] ADDR_TB_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  // per module n: function select, low byte, high byte at base + 16*n
  localparam logic [7:0] ADDR_MOD_BASE = 8'h20;
  localparam logic [7:0] OFS_FUNC = 8'h00;
  localparam logic [7:0] OFS_LOW = 8'h04;
  localparam logic [7:0] OFS_HIGH = 8'h08;
  localparam int MOD_STRIDE_SHIFT = 4;
  localparam int NUM_MODULES = 5;
  localparam int WDOG_MODULE = 4;
  // ==========================================================
  // field positions
  localparam int CTL_RUN_BIT = 6;
  localparam int MODE_WDOG_BIT = 6;
  localparam int FN_IRQ_EN_BIT = 0;
  localparam int FN_PWM_BIT = 1;
  localparam int FN_TOGGLE_BIT = 2;
  localparam int FN_MATCH_BIT = 3;
  localparam int FN_NEG_BIT = 4;
  localparam int FN_POS_BIT = 5;
  localparam int FN_COMPARE_BIT = 6;
  // ==========================================================
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
endpackage

// ---- rtl/cca_array.sv ----
// compare/capture array: shared 16-bit time base, five modules with one pin each
// assumes an apb master on clk_in and pins that come from outside the clock domain
// Behaviour
// [R1] five modules, each a 16-bit compare pair of two bytes and one pin
// [R2] module 0..4 pins are port 1 bits 3..7, in ascending order
// [R3] event flags are set by hardware only; software clears them
// [R4] low byte write disables compare; high byte write re-enables it
// [R5] software writes low byte first, then high byte, in compare modes
// [R6] selected pin edge copies counter into the pair and sets event flag
// [R7] event raises interrupt only when the module's interrupt enable is set; here function bit 0 or the module's irq enable register bit
// [R8] software timer sets event flag on full 16-bit counter match
// [R9] high-speed output toggles pin and sets flag on 16-bit match
// [R10] pwm: pin low while counter low byte below low byte, high above
// [R11] pwm: pin high when counter low byte equals low byte
// [R12] pwm: high byte moves into low byte when counter low wraps to zero
// [R13] only module 4 does watchdog; it keeps all other modes too
// [R14] module 4 match raises internal reset only when watchdog enable is set
// [R15] internal watchdog reset never drives the external reset pin
// [R16] software keeps module 4 compare ahead of the counter
// [R17] mode codes 20,10,30,48,4C,42 hex; bit 0 adds interrupt enable
// [R18] free-running 16-bit counter, bytes read/writable, counts when run bit set
//
// Decided for this implementation: the register addresses and register access over APB.
module cca_array (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [7:3] port1_in,
  output logic [7:3] port1_out,
  output logic [7:3] port1_oe_n_out,
  output logic irq_out,
  output logic wdog_reset_out,
  output logic rst_pin_drive_out
);
  // ==========================================================
  // bus decode
  logic [15:0] time_base;
  logic time_base_run_bit;
  logic module_watchdog_reset_enable;
  logic [4:0] module_event_flag;
  logic [4:0] irq_enable;
  logic [7:0] module_function_select [5];
  logic [7:0] module_compare_low_byte [5];
  logic [7:0] module_compare_high_byte [5];
  logic [4:0] compare_enable;
  logic [4:0] pin_level;
  logic [4:0] pin_sync1;
  logic [4:0] pin_sync2;
  logic [4:0] pin_prev;
  logic [4:0] next_flag_set;
  logic [4:0] match;
  logic [4:0] read_hit;
  wire bus_write = psel_in && penable_in && pwrite_in;
  wire bus_access = psel_in && penable_in;
  wire [7:0] wbyte = pwdata_in[7:0];
  wire wr_control = bus_write && (paddr_in == cca_pkg::ADDR_CONTROL);
  wire wr_mode = bus_write && (paddr_in == cca_pkg::ADDR_MODE);
  wire wr_tb_low = bus_write && (paddr_in == cca_pkg::ADDR_TB_LOW);
  wire wr_tb_high = bus_write && (paddr_in == cca_pkg::ADDR_TB_HIGH);
  wire wr_irq_en = bus_write && (paddr_in == cca_pkg::ADDR_IRQ_ENABLE);
  wire wr_irq_clr = bus_write && (paddr_in == cca_pkg::ADDR_IRQ_CLEAR);
  wire [7:0] mod_rel = paddr_in - cca_pkg::ADDR_MOD_BASE;
  wire [3:0] mod_idx = mod_rel[7:4];
  wire [7:0] mod_ofs = {4'h0, mod_rel[3:0]};
  wire in_mod_space = (paddr_in >= cca_pkg::ADDR_MOD_BASE) &&
                      (mod_idx < 4'(cca_pkg::NUM_MODULES));
  wire [7:0] counter_low = time_base[7:0];
  // the counter reaches 00 from FF only while running, so wrap is run && low == FF
  wire low_wrap = time_base_run_bit && (counter_low == cca_pkg::BYTE_ALL_ONES);
  assign pready_out = 1'b1;
  // ==========================================================
  // time base: free-running, software may overwrite either byte at any time
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      time_base <= cca_pkg::RESET_WORD;
    end else if (wr_tb_low) begin
      time_base[7:0] <= wbyte; // see [R18]
    end else if (wr_tb_high) begin
      time_base[15:8] <= wbyte; // see [R18]
    end else if (time_base_run_bit) begin
      time_base <= time_base + 16'h0001; // see [R18]
    end
  end

  // control and mode bits
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      time_base_run_bit <= 1'b0;
      module_watchdog_reset_enable <= 1'b0;
      irq_enable <= 5'h00;
    end else begin
      if (wr_control) time_base_run_bit <= wbyte[cca_pkg::CTL_RUN_BIT];
      if (wr_mode) module_watchdog_reset_enable <= wbyte[cca_pkg::MODE_WDOG_BIT];
      if (wr_irq_en) irq_enable <= wbyte[4:0];
    end
  end

  // ==========================================================
  // per-module logic
  genvar g;
  generate
    for (g = 0; g < cca_pkg::NUM_MODULES; g++) begin : gen_mod
      wire sel = in_mod_space && (mod_idx == 4'(g));
      wire wr_fn = bus_write && sel && (mod_ofs == cca_pkg::OFS_FUNC);
      wire wr_lo = bus_write && sel && (mod_ofs == cca_pkg::OFS_LOW);
      wire wr_hi = bus_write && sel && (mod_ofs == cca_pkg::OFS_HIGH);
      wire [7:0] fn = module_function_select[g];
      wire is_cmp = fn[cca_pkg::FN_COMPARE_BIT];
      wire is_pwm = is_cmp && fn[cca_pkg::FN_PWM_BIT];
      wire is_hso = is_cmp && fn[cca_pkg::FN_MATCH_BIT] && fn[cca_pkg::FN_TOGGLE_BIT];
      wire is_tmr = is_cmp && fn[cca_pkg::FN_MATCH_BIT] && !fn[cca_pkg::FN_TOGGLE_BIT];
      wire rise = pin_sync2[g] && !pin_prev[g];
      wire fall = !pin_sync2[g] && pin_prev[g];
      // capture uses edges on the synchronised pin, two cycles late
      wire cap_hit = !is_cmp && ((fn[cca_pkg::FN_POS_BIT] && rise) ||
                                 (fn[cca_pkg::FN_NEG_BIT] && fall)); // see [R6]
      wire eq16 = compare_enable[g] && (time_base ==
                  {module_compare_high_byte[g], module_compare_low_byte[g]});
      assign match[g] = eq16 && (is_tmr || is_hso); // see [R8] see [R9] see [R13]
      assign next_flag_set[g] = cap_hit || match[g];
      assign read_hit[g] = sel;

      // registers, capture and pwm reload
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          module_function_select[g] <= cca_pkg::RESET_BYTE;
          module_compare_low_byte[g] <= cca_pkg::RESET_BYTE;
          module_compare_high_byte[g] <= cca_pkg::RESET_BYTE;
          compare_enable[g] <= 1'b0;
        end else begin
          if (wr_fn) module_function_select[g] <= wbyte; // see [R17]
          if (cap_hit) begin
            module_compare_low_byte[g] <= counter_low; // see [R6]
            module_compare_high_byte[g] <= time_base[15:8];
          end else if (wr_lo) begin
            module_compare_low_byte[g] <= wbyte;
          end else if (wr_hi) begin
            module_compare_high_byte[g] <= wbyte;
          end else if (is_pwm && low_wrap) begin
            module_compare_low_byte[g] <= module_compare_high_byte[g]; // see [R12]
          end
          // the enable follows every byte write, even one that a capture overrides
          if (wr_lo) begin
            compare_enable[g] <= 1'b0; // see [R4]
          end else if (wr_hi) begin
            compare_enable[g] <= 1'b1; // see [R4]
          end
        end
      end

      // pin output: toggle on match, or pwm level
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_level[g] <= 1'b1;
        end else if (is_pwm && compare_enable[g]) begin
          pin_level[g] <= counter_low >= module_compare_low_byte[g]; // see [R10] see [R11]
        end else if (is_hso && match[g]) begin
          pin_level[g] <= !pin_level[g]; // see [R9]
        end
      end
      // pin is driven only in pwm or toggle output modes
      assign port1_oe_n_out[g + 3] = !(is_pwm || is_hso); // see [R2]
      assign port1_out[g + 3] = pin_level[g]; // see [R2]
    end
  endgenerate

  // ==========================================================
  // pin synchronisers and edge history
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_sync1 <= 5'h00;
      pin_sync2 <= 5'h00;
      pin_prev <= 5'h00;
    end else begin
      pin_sync1 <= port1_in;
      pin_sync2 <= pin_sync1;
      pin_prev <= pin_sync2;
    end
  end

  // event flags: set wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      module_event_flag <= 5'h00;
    end else begin
      module_event_flag <= (module_event_flag & ~({5{wr_irq_clr}} & wbyte[4:0]))
                           | next_flag_set; // see [R3]
    end
  end

  // interrupt gate: flag sticky, enable is the per-module function bit 0 or enable reg
  wire [4:0] fn_irq;
  generate
    for (g = 0; g < cca_pkg::NUM_MODULES; g++) begin : gen_irq
      assign fn_irq[g] = module_function_select[g][cca_pkg::FN_IRQ_EN_BIT] | irq_enable[g];
    end
  endgenerate
  assign irq_out = |(module_event_flag & fn_irq); // see [R7]

  // watchdog reset: internal pulse only, external reset pin never driven
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdog_reset_out <= 1'b0;
    end else begin
      wdog_reset_out <= module_watchdog_reset_enable &&
                        match[cca_pkg::WDOG_MODULE]; // see [R14]
    end
  end
  assign rst_pin_drive_out = 1'b0; // see [R15]

  // ==========================================================
  // read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (paddr_in)
      cca_pkg::ADDR_CONTROL: rd_byte = {1'b0, time_base_run_bit, 1'b0, module_event_flag};
      cca_pkg::ADDR_MODE: rd_byte = {1'b0, module_watchdog_reset_enable, 6'h00};
      cca_pkg::ADDR_TB_LOW: rd_byte = time_base[7:0];
      cca_pkg::ADDR_TB_HIGH: rd_byte = time_base[15:8];
      cca_pkg::ADDR_IRQ_STATUS: rd_byte = {3'h0, module_event_flag};
      cca_pkg::ADDR_IRQ_ENABLE: rd_byte = {3'h0, irq_enable};
      default: begin
        if (in_mod_space) begin
          case (mod_ofs)
            cca_pkg::OFS_FUNC: rd_byte = module_function_select[mod_idx[2:0]];
            cca_pkg::OFS_LOW: rd_byte = module_compare_low_byte[mod_idx[2:0]];
            cca_pkg::OFS_HIGH: rd_byte = module_compare_high_byte[mod_idx[2:0]];
            default: rd_byte = 8'h00;
          endcase
        end
      end
    endcase
  end
  // read data is latched at the setup edge so it stands unchanged through the access phase
  logic [7:0] read_word;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_word <= cca_pkg::RESET_BYTE;
    end else if (psel_in && !penable_in) begin
      read_word <= rd_byte;
    end
  end
  assign prdata_out = {24'h00_0000, read_word};
  // unmapped addresses answer with an error, writes to them are dropped
  wire mapped = (paddr_in <= cca_pkg::ADDR_IRQ_CLEAR) ||
                (|read_hit && mod_ofs <= cca_pkg::OFS_HIGH);
  assign pslverr_out = bus_access && !mapped;

  // ==========================================================
  // checks
  wdog_match_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R14]
    (module_watchdog_reset_enable && match[4]) |=> wdog_reset_out)
    else $error("watchdog match without reset");
  wdog_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R14]
    wdog_reset_out |-> $past(module_watchdog_reset_enable))
    else $error("watchdog reset while disabled");
  flag_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R3]
    (module_event_flag[0] && !wr_irq_clr) |=> module_event_flag[0])
    else $error("event flag cleared by hardware");
  flag_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R8]
    next_flag_set[1] |=> module_event_flag[1])
    else $error("event flag not set");
  low_disable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R4]
    gen_mod[2].wr_lo |=> !compare_enable[2])
    else $error("low byte write kept compare on");
  high_enable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R4]
    gen_mod[2].wr_hi |=> compare_enable[2])
    else $error("high byte write left compare off");
  // a rising edge is a low then a high on the synchronised pin
  sequence rise_seen;
    !pin_sync2[0] ##1 pin_sync2[0];
  endsequence
  cap_edge_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R6]
    (rise_seen ##0 (module_function_select[0][cca_pkg::FN_POS_BIT] &&
     !module_function_select[0][cca_pkg::FN_COMPARE_BIT])) |=> module_event_flag[0])
    else $error("capture edge missed");
  cap_value_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R6]
    gen_mod[0].cap_hit |=>
    ({module_compare_high_byte[0], module_compare_low_byte[0]} == $past(time_base)))
    else $error("capture took the wrong count");
  irq_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R7]
    (|(module_event_flag & irq_enable)) |-> irq_out)
    else $error("enabled event flag without interrupt");
  rst_pin_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R15]
    !rst_pin_drive_out)
    else $error("external reset pin driven");
  // pwm level and reload on module 0, toggle output on module 3
  pwm_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R10]
    (gen_mod[0].is_pwm && compare_enable[0] && counter_low < module_compare_low_byte[0])
    |=> !pin_level[0])
    else $error("pwm pin high below compare");
  pwm_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R11]
    (gen_mod[0].is_pwm && compare_enable[0] && counter_low >= module_compare_low_byte[0])
    |=> pin_level[0])
    else $error("pwm pin low at or above compare");
  pwm_reload_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R12]
    (gen_mod[0].is_pwm && low_wrap && !gen_mod[0].wr_lo && !gen_mod[0].wr_hi) |=>
    (module_compare_low_byte[0] == $past(module_compare_high_byte[0])))
    else $error("pwm reload missed at wrap");
  hso_toggle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R9]
    (gen_mod[3].is_hso && !gen_mod[3].is_pwm && match[3]) |=>
    (pin_level[3] != $past(pin_level[3])))
    else $error("toggle output did not toggle");
  tb_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R18]
    (time_base_run_bit && !wr_tb_low && !wr_tb_high) |=>
    (time_base == $past(time_base) + 16'h0001))
    else $error("time base did not count");
  tb_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see [R18]
    (!time_base_run_bit && !wr_tb_low && !wr_tb_high) |=> $stable(time_base))
    else $error("time base moved while stopped");
endmodule

// ---- bench/cca_pins_model.sv ----
// pin model: outside signal sources on the five module pins
// assumes the bench sets lvl_in right after clock edges
module cca_pins_model (
  input wire logic [7:3] lvl_in,
  input wire logic [7:3] drive_in,
  input wire logic [7:3] drive_oe_n_in,
  output logic [7:3] pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // wire level: the block's drive wins where its enable is low
  assign pin_out = (~drive_oe_n_in & drive_in) | (drive_oe_n_in & lvl_in);
endmodule

// ---- bench/cca_array_compare_capture_modules_test.sv ----
// bench for the compare/capture array: apb master, pin sources, scenarios
// assumes an apb slave on clk_in and pins resolved by the pin model
module counter_array_compare_capture_modules_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_n_in, psel, penable, pwrite, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, irq, wdog, rst_drv;
  logic [7:3] lvl, p_in, p_out, p_oe_n;
  int failures = 0, n_tests = 0;
  int n_wdog = 0, n_rst_drv = 0;
  cca_array dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .port1_in(p_in), .port1_out(p_out),
    .port1_oe_n_out(p_oe_n), .irq_out(irq), .wdog_reset_out(wdog), .rst_pin_drive_out(rst_drv));
  cca_pins_model pins_u (.lvl_in(lvl), .drive_in(p_out), .drive_oe_n_in(p_oe_n),
    .pin_out(p_in));
  // ==========================================================
  // clock and watchdog; a hang counts as a mismatch
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    close_out();
  end
  // watchdog pulses and reset pin drive, counted over the whole run
  always @(posedge clk_in) begin
    if (wdog === 1'b1) n_wdog++;
    if (rst_drv !== 1'b0) n_rst_drv++;
  end
  // ==========================================================
  // apb master: hold request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] mad(input int n, input logic [7:0] ofs);
    return cca_pkg::ADDR_MOD_BASE + 8'((n << cca_pkg::MOD_STRIDE_SHIFT)) + ofs;
  endfunction
  // stop the time base and load it, low byte then high byte
  task automatic set_count(input logic [15:0] v);
    apb(1'b1, cca_pkg::ADDR_CONTROL, 32'h0000_0000);
    apb(1'b1, cca_pkg::ADDR_TB_LOW, {24'h00_0000, v[7:0]});
    apb(1'b1, cca_pkg::ADDR_TB_HIGH, {24'h00_0000, v[15:8]});
  endtask
  task automatic cmp_pair(input int n, input logic [15:0] v);
    apb(1'b1, mad(n, cca_pkg::OFS_LOW), {24'h00_0000, v[7:0]});
    apb(1'b1, mad(n, cca_pkg::OFS_HIGH), {24'h00_0000, v[15:8]});
  endtask
  task automatic run();
    apb(1'b1, cca_pkg::ADDR_CONTROL, 32'h0000_0040);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    apb(1'b0, cca_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(rv, 32'h0000_0000);
    chk({27'h000_0000, p_out}, 32'h0000_001f);
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk({31'h0000_0000, last_err}, 32'h0000_0001);
  endtask
  // module 0 rising with interrupt, 1 falling only, 2 both edges; counter held
  task automatic t_capture();
    apb(1'b1, mad(0, cca_pkg::OFS_FUNC), 32'h0000_0021);
    apb(1'b1, mad(1, cca_pkg::OFS_FUNC), 32'h0000_0010);
    apb(1'b1, mad(2, cca_pkg::OFS_FUNC), 32'h0000_0030);
    set_count(16'h1234);
    @(posedge clk_in);
    lvl <= 5'b00111;
    repeat (6) @(posedge clk_in);
    apb(1'b0, mad(0, cca_pkg::OFS_LOW), 32'h0000_0000);
    chk(rv, 32'h0000_0034);
    apb(1'b0, mad(0, cca_pkg::OFS_HIGH), 32'h0000_0000);
    chk(rv, 32'h0000_0012);
    apb(1'b0, cca_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(rv, 32'h0000_0005);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    apb(1'b1, cca_pkg::ADDR_IRQ_CLEAR, 32'h0000_0005);
    lvl <= 5'b00001;
    repeat (6) @(posedge clk_in);
    apb(1'b0, cca_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(rv, 32'h0000_0006);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    apb(1'b0, mad(2, cca_pkg::OFS_HIGH), 32'h0000_0000);
    chk(rv, 32'h0000_0012);
    for (int n = 0; n < 3; n++) apb(1'b1, mad(n, cca_pkg::OFS_FUNC), 32'h0000_0000);
    apb(1'b1, cca_pkg::ADDR_IRQ_CLEAR, 32'h0000_001f);
  endtask
  task automatic t_timer();
    set_count(16'h0000);
    apb(1'b1, mad(1, cca_pkg::OFS_FUNC), 32'h0000_0048);
    cmp_pair(1, 16'h0010);
    apb(1'b1, mad(2, cca_pkg::OFS_FUNC), 32'h0000_0048);
    apb(1'b1, mad(2, cca_pkg::OFS_HIGH), 32'h0000_0000);
    apb(1'b1, mad(2, cca_pkg::OFS_LOW), 32'h0000_0010);
    apb(1'b1, mad(3, cca_pkg::OFS_FUNC), 32'h0000_004C);
    cmp_pair(3, 16'h0010);
    run();
    repeat (40) @(posedge clk_in);
    apb(1'b0, cca_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(rv, 32'h0000_000a);
    chk({27'h000_0000, p_out}, 32'h0000_0017);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    apb(1'b1, cca_pkg::ADDR_IRQ_ENABLE, 32'h0000_0002);
    // the enable lands at the access edge, so look one edge later
    @(posedge clk_in);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    apb(1'b1, cca_pkg::ADDR_IRQ_ENABLE, 32'h0000_0000);
    apb(1'b1, cca_pkg::ADDR_IRQ_CLEAR, 32'h0000_001f);
    for (int n = 1; n < 4; n++) apb(1'b1, mad(n, cca_pkg::OFS_FUNC), 32'h0000_0000);
  endtask
  task automatic t_pwm();
    int ones;
    ones = 0;
    apb(1'b1, mad(0, cca_pkg::OFS_FUNC), 32'h0000_0042);
    apb(1'b1, mad(0, cca_pkg::OFS_HIGH), 32'h0000_0080);
    set_count(16'h00F0);
    run();
    repeat (40) @(posedge clk_in);
    apb(1'b0, mad(0, cca_pkg::OFS_LOW), 32'h0000_0000);
    chk(rv, 32'h0000_0080);
    chk({31'h0000_0000, p_oe_n[3]}, 32'h0000_0000);
    // a full low-byte period, so pipeline delay cannot change the count
    for (int i = 0; i < 256; i++) begin
      @(posedge clk_in);
      if (p_out[3] === 1'b1) ones++;
    end
    chk(ones, 128);
    apb(1'b1, mad(0, cca_pkg::OFS_FUNC), 32'h0000_0000);
  endtask
  // software keeps module 4 ahead of the counter, then stops feeding it
  task automatic t_wdog();
    apb(1'b1, cca_pkg::ADDR_MODE, 32'h0000_0040);
    apb(1'b1, mad(4, cca_pkg::OFS_FUNC), 32'h0000_0048);
    cmp_pair(4, 16'h0040);
    set_count(16'h0000);
    run();
    for (int k = 2; k < 6; k++) begin
      repeat (40) @(posedge clk_in);
      cmp_pair(4, 16'(k * 64));
    end
    chk(n_wdog, 0);
    repeat (200) @(posedge clk_in);
    chk(n_wdog, 1);
    chk(n_rst_drv, 0);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence; the watchdog scenario goes last as it leaves module 4 armed
  initial begin
    rst_n_in = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; lvl = 5'b00000;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_capture();
    t_timer();
    t_pwm();
    t_wdog();
    close_out();
  end
endmodule
